// ### dpsr_top.sv
// Dual-port synchronous static memory, 18-bit words, with per-port burst counters.
// What this block does
// - Array of 18-bit words, 4K or 8K deep, shared by both ports.
// - Both ports access any word independently in the same cycle.
// - Control, address and write data are captured on the rising clock edge.
// - Pipelined mode adds an output register; flow-through bypasses it.
// - Each port picks its output mode from its own mode-select input.
// - A port is deselected and idle when either chip select is inactive.
// - Pipelined outputs return only after one selected cycle.
// - With counter enable the access address comes from the burst counter.
// - Address strobe loads the burst counter with the presented address.
// - Counter advances by one each rising edge while counter enable holds.
// - A counted burst accesses one sequential word each cycle.
// - Counter spans full depth and wraps from last word to zero.
// - Counter-reset input clears the burst counter.
// - Counter reset zeroes the counter and beats strobe and count enable.
// - Count enable is ignored while strobe or counter reset is low.
// - Byte selects gate writes and read drive; reading also needs output enable.
// - A write completes within one cycle, independent of clock high time.
`timescale 1ns/1ps
`include "dpsr_defs.svh"
module dpsr_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  input  wire logic [`DPSR_ADDR_W-1:0] l_addr_i,
  input  wire logic                    l_addr_strobe_n_i,
  input  wire logic                    l_count_en_n_i,
  input  wire logic                    l_count_clear_n_i,
  input  wire logic                    l_chip_sel_low_active_i,
  input  wire logic                    l_chip_sel_high_active_i,
  input  wire logic                    l_write_n_i,
  input  wire logic                    l_out_en_n_i,
  input  wire logic                    l_low_byte_sel_n_i,
  input  wire logic                    l_high_byte_sel_n_i,
  input  wire logic                    l_output_mode_sel_i,
  input  wire logic [`DPSR_DATA_W-1:0] l_data_i,
  output logic      [`DPSR_DATA_W-1:0] l_data_o,
  output logic      [1:0]              l_data_oe_o,
  input  wire logic [`DPSR_ADDR_W-1:0] r_addr_i,
  input  wire logic                    r_addr_strobe_n_i,
  input  wire logic                    r_count_en_n_i,
  input  wire logic                    r_count_clear_n_i,
  input  wire logic                    r_chip_sel_low_active_i,
  input  wire logic                    r_chip_sel_high_active_i,
  input  wire logic                    r_write_n_i,
  input  wire logic                    r_out_en_n_i,
  input  wire logic                    r_low_byte_sel_n_i,
  input  wire logic                    r_high_byte_sel_n_i,
  input  wire logic                    r_output_mode_sel_i,
  input  wire logic [`DPSR_DATA_W-1:0] r_data_i,
  output logic      [`DPSR_DATA_W-1:0] r_data_o,
  output logic      [1:0]              r_data_oe_o
);

  // The small variant ignores the top address bit so the counter wraps at 4K.
  localparam dpsr_pkg::dpsr_addr_t ADDR_MASK = LARGE_VARIANT ?
    dpsr_pkg::dpsr_addr_t'(`DPSR_WORDS_LARGE - 1) : dpsr_pkg::dpsr_addr_t'(`DPSR_WORDS_SMALL - 1);

  // Storage array sized for the larger variant; both ports reach every word.
  dpsr_pkg::dpsr_word_t mem [0:`DPSR_WORDS_LARGE-1];

  // Port inputs gathered into arrays so one generate loop serves both ports.
  dpsr_pkg::dpsr_addr_t p_addr      [`DPSR_PORTS];
  dpsr_pkg::dpsr_word_t p_wdata     [`DPSR_PORTS];
  logic                 p_ads_n     [`DPSR_PORTS];
  logic                 p_count_en_n_n   [`DPSR_PORTS];
  logic                 p_clr_n     [`DPSR_PORTS];
  logic                 p_sel       [`DPSR_PORTS];
  logic                 p_wr_n      [`DPSR_PORTS];
  logic                 p_oe_n      [`DPSR_PORTS];
  logic [1:0]           p_be_n      [`DPSR_PORTS];
  logic                 p_mode      [`DPSR_PORTS];
  dpsr_pkg::dpsr_word_t p_rdata     [`DPSR_PORTS];
  logic [1:0]           p_drive     [`DPSR_PORTS];

  // Captured access state, one set per port.
  dpsr_pkg::dpsr_addr_t cnt_r       [`DPSR_PORTS];
  dpsr_pkg::dpsr_addr_t cnt_nxt     [`DPSR_PORTS];
  dpsr_pkg::dpsr_word_t wdata_r     [`DPSR_PORTS];
  logic                 sel_r       [`DPSR_PORTS];
  logic                 wr_r        [`DPSR_PORTS];
  logic [1:0]           be_r        [`DPSR_PORTS];
  dpsr_pkg::dpsr_mode_t mode_r      [`DPSR_PORTS];
  dpsr_pkg::dpsr_word_t pipe_data_r [`DPSR_PORTS];
  logic                 pipe_rd_r   [`DPSR_PORTS];
  logic [1:0]           pipe_be_r   [`DPSR_PORTS];

  // Both chip selects must be active for the port to take part in a cycle.
  function automatic logic dpsr_selected(input logic sel_low_active, input logic sel_high_active);
    dpsr_selected = !sel_low_active && sel_high_active;
  endfunction

  // Left port pins map onto index 0 and right port pins onto index 1.
  assign p_addr[0]    = l_addr_i;
  assign p_addr[1]    = r_addr_i;
  assign p_wdata[0]   = l_data_i;
  assign p_wdata[1]   = r_data_i;
  assign p_ads_n[0]   = l_addr_strobe_n_i;
  assign p_ads_n[1]   = r_addr_strobe_n_i;
  assign p_count_en_n_n[0] = l_count_en_n_i;
  assign p_count_en_n_n[1] = r_count_en_n_i;
  assign p_clr_n[0]   = l_count_clear_n_i;
  assign p_clr_n[1]   = r_count_clear_n_i;
  assign p_sel[0]     = dpsr_selected(l_chip_sel_low_active_i, l_chip_sel_high_active_i);
  assign p_sel[1]     = dpsr_selected(r_chip_sel_low_active_i, r_chip_sel_high_active_i);
  assign p_wr_n[0]    = l_write_n_i;
  assign p_wr_n[1]    = r_write_n_i;
  assign p_oe_n[0]    = l_out_en_n_i;
  assign p_oe_n[1]    = r_out_en_n_i;
  assign p_be_n[0]    = {l_high_byte_sel_n_i, l_low_byte_sel_n_i};
  assign p_be_n[1]    = {r_high_byte_sel_n_i, r_low_byte_sel_n_i};
  assign p_mode[0]    = l_output_mode_sel_i;
  assign p_mode[1]    = r_output_mode_sel_i;

  // Each port is a self-contained pipeline; nothing crosses between them except the array.
  generate
    for (genvar p = 0; p < `DPSR_PORTS; p++)
    begin : g_port
      // Next access address: clear beats strobe, strobe beats count enable, else hold.
      always_comb
      begin
        if (!p_clr_n[p])
          cnt_nxt[p] = `DPSR_CNT_CLEAR;
        else if (!p_ads_n[p])
          cnt_nxt[p] = p_addr[p] & ADDR_MASK;
        else if (!p_count_en_n_n[p])
          cnt_nxt[p] = (cnt_r[p] + 1'b1) & ADDR_MASK;
        else
          cnt_nxt[p] = cnt_r[p];
      end

      // Burst counter doubles as the captured access address.
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          cnt_r[p] <= `DPSR_CNT_CLEAR;
        else
          cnt_r[p] <= cnt_nxt[p];
      end

      // Input register for control and write data, taken on every rising edge.
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sel_r[p]   <= 1'b0;
          wr_r[p]    <= 1'b0;
          be_r[p]    <= 2'h0;
          wdata_r[p] <= `DPSR_DATA_CLEAR;
        end
        else
        begin
          sel_r[p]   <= p_sel[p];
          wr_r[p]    <= !p_wr_n[p];
          be_r[p]    <= ~p_be_n[p];
          wdata_r[p] <= p_wdata[p];
        end
      end

      // The mode pin is meant to be static, but capturing it keeps the mux glitch free.
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mode_r[p] <= dpsr_pkg::DPSR_FLOW_THROUGH;
        else
          mode_r[p] <= p_mode[p] ? dpsr_pkg::DPSR_PIPELINED : dpsr_pkg::DPSR_FLOW_THROUGH;
      end

      // Output register of the pipelined path; a deselected cycle clears its read flag.
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pipe_data_r[p] <= `DPSR_DATA_CLEAR;
          pipe_rd_r[p]   <= 1'b0;
          pipe_be_r[p]   <= 2'h0;
        end
        else
        begin
          pipe_data_r[p] <= mem[cnt_r[p]];
          pipe_rd_r[p]   <= sel_r[p] && !wr_r[p];
          pipe_be_r[p]   <= be_r[p];
        end
      end

      // Read data and per-byte drive, taken from the register or straight from the array.
      always_comb
      begin
        unique case (mode_r[p])
          dpsr_pkg::DPSR_PIPELINED:
          begin
            p_rdata[p] = pipe_data_r[p];
            p_drive[p] = (pipe_rd_r[p] && !p_oe_n[p]) ? pipe_be_r[p] : 2'h0;
          end
          dpsr_pkg::DPSR_FLOW_THROUGH:
          begin
            p_rdata[p] = mem[cnt_r[p]];
            p_drive[p] = (sel_r[p] && !wr_r[p] && !p_oe_n[p]) ? be_r[p] : 2'h0;
          end
          default:
          begin
            p_rdata[p] = `DPSR_DATA_CLEAR;
            p_drive[p] = 2'h0;
          end
        endcase
      end
    end
  endgenerate

  // Array write: one edge after capture, so a write never spans more than a cycle.
  // Both ports write in the same process; on a same-word collision the right port lands last.
  always_ff @(posedge clk_sys_i)
  begin
    for (int p = 0; p < `DPSR_PORTS; p++)
    begin
      if (sel_r[p] && wr_r[p])
      begin
        if (be_r[p][0])
          mem[cnt_r[p]][`DPSR_HALF_W-1:0] <= wdata_r[p][`DPSR_HALF_W-1:0];
        if (be_r[p][1])
          mem[cnt_r[p]][`DPSR_DATA_W-1:`DPSR_HALF_W] <= wdata_r[p][`DPSR_DATA_W-1:`DPSR_HALF_W];
      end
    end
  end

  // Pin-side outputs for the two ports.
  assign l_data_o    = p_rdata[0];
  assign l_data_oe_o = p_drive[0];
  assign r_data_o    = p_rdata[1];
  assign r_data_oe_o = p_drive[1];

endmodule

// ### dpsr_defs.svh
// Constants for the dual-port synchronous static memory with burst counters.
`ifndef DPSR_DEFS_SVH
`define DPSR_DEFS_SVH
`define DPSR_DATA_W      18
`define DPSR_HALF_W      9
`define DPSR_ADDR_W      13
`define DPSR_WORDS_LARGE 8192
`define DPSR_WORDS_SMALL 4096
`define DPSR_PORTS       2
`define DPSR_CNT_CLEAR   13'h0000
`define DPSR_DATA_CLEAR  18'h00000
`endif

// ### dpsr_pkg.sv
// Types shared by the dual-port synchronous static memory.
`include "dpsr_defs.svh"
package dpsr_pkg;
  typedef logic [`DPSR_DATA_W-1:0] dpsr_word_t;
  typedef logic [`DPSR_ADDR_W-1:0] dpsr_addr_t;
  typedef enum logic [1:0]
  {
    DPSR_FLOW_THROUGH = 2'h1,
    DPSR_PIPELINED    = 2'h2
  } dpsr_mode_t;
endpackage

// ### dpsr_mst.sv
// Bus master model that drives every input of one memory port.
`timescale 1ns/1ps
module dpsr_mst (
  output logic [9:0]  ctl_o,
  output logic [12:0] addr_o,
  output logic [17:0] data_o,
  input  wire logic   clk_i
);
  // Idle: deselected, all strobes off, mode low for flow-through.
  initial
  begin
    ctl_o  = 10'h3DE;
    addr_o = 13'h0000;
    data_o = 18'h00000;
  end
  // One request a cycle, launched just after the edge; unused write data is
  // inverted so that a stale word can never pass for a fresh one.
  task automatic cyc(input logic [9:0] c, input logic [12:0] a, input logic [17:0] d);
    @(posedge clk_i);
    ctl_o  <= c;
    addr_o <= a;
    data_o <= c[4] ? ~data_o : d;
  endtask
endmodule

// ### dpsr_asserts.sv
// Checker for the left port of the dual-port memory.
`timescale 1ns/1ps
module dpsr_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic [12:0] l_addr_i,
  input wire logic        l_addr_strobe_n_i,
  input wire logic        l_count_clear_n_i,
  input wire logic        l_chip_sel_low_active_i,
  input wire logic        l_chip_sel_high_active_i,
  input wire logic        l_write_n_i,
  input wire logic        l_out_en_n_i,
  input wire logic        l_low_byte_sel_n_i,
  input wire logic        l_output_mode_sel_i,
  input wire logic [17:0] l_data_i,
  input wire logic [17:0] l_data_o,
  input wire logic [1:0]  l_data_oe_o
);
  logic sel;
  logic acc;
  // A selected, strobed access with the low half enabled.
  assign sel = !l_chip_sel_low_active_i && l_chip_sel_high_active_i;
  assign acc = sel && !l_low_byte_sel_n_i && !l_addr_strobe_n_i && l_count_clear_n_i;
  default clocking dck @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  oe_gate_a: assert property (l_out_en_n_i |-> l_data_oe_o == 2'h0)
    else $error("drive with output enable off");
  desel_quiet_a: assert property (!sel [*2] |=> l_data_oe_o == 2'h0)
    else $error("drive while deselected");
  low_half_a: assert property (l_low_byte_sel_n_i [*2] |=> !l_data_oe_o[0])
    else $error("low half driven");
  write_quiet_a: assert property (!l_write_n_i [*2] |=> l_data_oe_o == 2'h0)
    else $error("drive during writes");
  low_drive_a: assert property ((sel && l_write_n_i && !l_low_byte_sel_n_i) [*3] ##1 !l_out_en_n_i |-> l_data_oe_o[0])
    else $error("read not driven");
  ft_read_a: assert property (acc && !l_output_mode_sel_i && !l_write_n_i ##1 acc && !l_output_mode_sel_i &&
    l_write_n_i && $stable(l_addr_i) |=> l_data_o[8:0] == $past(l_data_i[8:0], 2))
    else $error("flow-through read wrong");
  pipe_read_a: assert property (acc && l_output_mode_sel_i && !l_write_n_i ##1 acc && l_output_mode_sel_i &&
    l_write_n_i && $stable(l_addr_i) ##1 l_output_mode_sel_i |=> l_data_o[8:0] == $past(l_data_i[8:0], 3))
    else $error("pipelined read wrong");
  clr_zero_a: assert property (sel && !l_count_clear_n_i && !l_write_n_i && !l_low_byte_sel_n_i ##1 acc &&
    l_write_n_i && !l_output_mode_sel_i && l_addr_i == 13'h0000 |=> l_data_o[8:0] == $past(l_data_i[8:0], 2))
    else $error("clear not to word zero");
endmodule
bind dpsr_top dpsr_chk i_dpsr_chk (.*);

// ### testbench.sv
// Self-checking testbench: two bus masters exercise both memory ports.
`timescale 1ns/1ps
module testbench;
  localparam logic [9:0] RD = 10'h1B0, RDC = 10'h0B0, PIP = 10'h1B1, NOE = 10'h1B8, CLR = 10'h030, IDL = 10'h3DE;
  localparam logic [9:0] WR = 10'h1A0, WRP = 10'h1A1, BW = 10'h2A0, BR = 10'h2B0, CW = 10'h120, DSW = 10'h180;
  localparam logic [17:0] EX [3] = '{18'h11111, 18'h22222, 18'h33333};
  logic        clk;
  logic        rst_b;
  logic [9:0]  lc, rc;
  logic [12:0] la, ra;
  logic [17:0] ld, rd_w, lq, rq;
  logic [1:0]  lo, ro;
  int          err_count, check_count, cycle_count;
  dpsr_mst i_dpsr_mst_l (.ctl_o(lc), .addr_o(la), .data_o(ld), .clk_i(clk));
  dpsr_mst i_dpsr_mst_r (.ctl_o(rc), .addr_o(ra), .data_o(rd_w), .clk_i(clk));
  dpsr_top i_dpsr_top (.clk_sys_i(clk), .rst_b_i(rst_b), .l_addr_i(la), .l_addr_strobe_n_i(lc[9]),
    .l_count_en_n_i(lc[8]), .l_count_clear_n_i(lc[7]), .l_chip_sel_low_active_i(lc[6]),
    .l_chip_sel_high_active_i(lc[5]), .l_write_n_i(lc[4]), .l_out_en_n_i(lc[3]), .l_low_byte_sel_n_i(lc[2]),
    .l_high_byte_sel_n_i(lc[1]), .l_output_mode_sel_i(lc[0]), .l_data_i(ld), .l_data_o(lq), .l_data_oe_o(lo),
    .r_addr_i(ra), .r_addr_strobe_n_i(rc[9]), .r_count_en_n_i(rc[8]), .r_count_clear_n_i(rc[7]),
    .r_chip_sel_low_active_i(rc[6]), .r_chip_sel_high_active_i(rc[5]), .r_write_n_i(rc[4]),
    .r_out_en_n_i(rc[3]), .r_low_byte_sel_n_i(rc[2]), .r_high_byte_sel_n_i(rc[1]),
    .r_output_mode_sel_i(rc[0]), .r_data_i(rd_w), .r_data_o(rq), .r_data_oe_o(ro));
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Counts one comparison; four-state compare so an unknown never passes.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hands one request to the left or right master.
  task automatic go(input bit p, input logic [9:0] c, input logic [12:0] a, input logic [17:0] d);
    if (p)
      i_dpsr_mst_r.cyc(c, a, d);
    else
      i_dpsr_mst_l.cyc(c, a, d);
  endtask
  // Holds one read n cycles, then judges data and full drive once settled.
  task automatic rd(input bit p, input logic [9:0] c, input logic [12:0] a, input int n, input logic [17:0] e);
    repeat (n) go(p, c, a, 18'h00000);
    @(negedge clk);
    chk(p ? rq : lq, e);
    chk({16'h0000, p ? ro : lo}, 18'h00003);
  endtask
  // Each port writes; both ports then read the left word in the same cycles, then the left port reads the right word.
  task automatic t_cross();
    fork
      begin
        go(0, WR, 13'h1ABC, 18'h2A5A5);
        rd(0, RDC, 13'h1ABC, 2, 18'h2A5A5);
      end
      begin
        go(1, WR, 13'h0123, 18'h15A5A);
        rd(1, RD, 13'h1ABC, 2, 18'h2A5A5);
      end
    join
    rd(0, RD, 13'h0123, 2, 18'h15A5A);
  endtask
  // Pipelined reads: one right after a write, one right after deselection.
  task automatic t_pipe();
    fork
      begin
        go(0, WRP, 13'h0ABC, 18'h3FFFF);
        rd(0, PIP, 13'h0ABC, 3, 18'h3FFFF);
      end
      begin
        go(1, IDL, 13'h0000, 18'h00000);
        rd(1, PIP, 13'h0123, 3, 18'h15A5A);
      end
    join
  endtask
  // Counted burst across the top of the array, written then read back.
  task automatic t_burst();
    go(0, WR, 13'h1FFE, 18'h11111);
    go(0, BW, 13'h0000, 18'h22222);
    go(0, BW, 13'h0000, 18'h33333);
    go(0, RD, 13'h1FFE, 18'h00000);
    for (int i = 0; i < 3; i++)
    begin
      go(0, BR, 13'h0000, 18'h00000);
      @(negedge clk);
      chk(lq, EX[i]);
    end
    rd(1, RD, 13'h0000, 2, 18'h33333);
  endtask
  // Clear wins over strobe and count; then deselect and byte gating.
  task automatic t_clear_gate();
    rd(0, CLR, 13'h1FFF, 2, 18'h33333);
    go(0, CW, 13'h0555, 18'h0ABCD);
    rd(0, RD, 13'h0000, 2, 18'h0ABCD);
    go(0, DSW, 13'h0000, 18'h3FFFF);
    go(0, WR | 10'h002, 13'h0000, 18'h00F0F);
    rd(0, RD, 13'h0000, 2, 18'h0AB0F);
    go(1, NOE, 13'h0000, 18'h00000);
    @(negedge clk);
    chk({16'h0000, ro}, 18'h00000);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang is cut short well past the expected run of about 32 cycles.
  always @(posedge clk)
  begin
    cycle_count++;
    if (cycle_count == 500)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    // Step off the edge so the masters' first wait cannot race the clock port.
    @(negedge clk);
    t_cross();
    t_pipe();
    t_burst();
    t_clear_gate();
    wrap_up();
  end
endmodule
